// File: inc/dfpm_defines.svh
`ifndef DFPM_DEFINES_SVH
`define DFPM_DEFINES_SVH
// ==========================================
// Register byte offsets
`define DFPM_OFS_CTRL 8'h00
`define DFPM_OFS_SPD_BAND 8'h04
`define DFPM_OFS_SPD_TIME 8'h08
`define DFPM_OFS_ENC_TIME 8'h0c
`define DFPM_OFS_UNDERVOLTAGE_TRIP_DELAY 8'h10
`define DFPM_OFS_OUT_SEL 8'h14
`define DFPM_OFS_STATUS 8'h18
`define DFPM_OFS_IRQ_STAT 8'h1c
`define DFPM_OFS_IRQ_CLR 8'h20
`define DFPM_OFS_IRQ_EN 8'h24
`define DFPM_OFS_TRIP_CLR 8'h28
// ==========================================
// Field positions
`define DFPM_CTRL_SPD_EN 0
`define DFPM_CTRL_ENC_EN 1
`define DFPM_CTRL_FAN_MODE 2
`define DFPM_CTRL_MODE_LSB 4
`define DFPM_CTRL_MODE_MSB 6
`define DFPM_SEL_RELAY1_LSB 0
`define DFPM_SEL_RELAY2_LSB 8
`define DFPM_SEL_OC_LSB 16
// ==========================================
// Reset values and codes
`define DFPM_RST_CTRL 32'h0000_0003
`define DFPM_RST_SPD_BAND 16'h07d0
`define DFPM_RST_SPD_TIME 16'h000a
`define DFPM_RST_ENC_TIME 16'h000a
`define DFPM_RST_UNDERVOLTAGE_TRIP_DELAY 16'h0000
`define DFPM_RST_OUT_SEL 32'h0000_0000
`define DFPM_MODE_VECTOR 3'h4
`define DFPM_FUNC_FAN_WARN 8'h08
`define DFPM_FUNC_LOW_VOLT 8'h0b
// ==========================================
// Timing
`define DFPM_CLK_HZ 50000000
`define DFPM_TICK_MS 100
`endif

// File: inc/dfpm_pkg.sv
`default_nettype none
package dfpm_pkg;
   // ==========================================
   // Configuration carried from the register file
   typedef struct packed {
      logic [2:0] mode;
      logic fan_warn_mode;
      logic enc_check_en;
      logic spd_trip_en;
   } dfpm_ctrl_s;

   // ==========================================
   // Synchronised pin inputs
   typedef struct packed {
      logic overheat;
      logic dc_low;
      logic power_lost;
      logic fan_err;
      logic enc_wire_ok;
      logic enc_present;
   } dfpm_pins_s;

   // ==========================================
   // Event bits, same layout in status, clear and enable
   typedef struct packed {
      logic uv_warn;
      logic fan_warn;
      logic lv_trip;
      logic fan_trip;
      logic enc_trip;
      logic spd_trip;
   } dfpm_evt_s;
endpackage : dfpm_pkg
`default_nettype wire

// File: verilog/dfpm_sync.sv
`default_nettype none
module dfpm_sync #(
   parameter int WIDTH = 6
) (
   // Clock and control
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   // Data
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   // ==========================================
   // Two flops per bit; first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta;
         always_ff @(posedge clock) begin
            if (srst) begin
               meta <= 1'b0;
               dout[i] <= 1'b0;
            end else if (ce) begin
               meta <= din[i];
               dout[i] <= meta;
            end
         end
      end
   endgenerate
endmodule : dfpm_sync
`default_nettype wire

// File: verilog/dfpm_timer.sv
`default_nettype none
module dfpm_timer #(
   parameter int WIDTH = 16
) (
   // Clock and control
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   input wire logic tick,
   // Condition and limit in ticks
   input wire logic cond,
   input wire logic [WIDTH-1:0] limit,
   output logic expired
);
   logic [WIDTH-1:0] count;

   // ==========================================
   // Any break in the condition restarts the count
   always_ff @(posedge clock) begin
      if (srst) begin
         count <= '0;
      end else if (ce) begin
         if (!cond) begin
            count <= '0;
         end else if (tick && count != {WIDTH{1'b1}}) begin
            count <= count + 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         expired <= 1'b0;
      end else if (ce) begin
         expired <= cond && (count >= limit);
      end
   end
endmodule : dfpm_timer
`default_nettype wire

// File: verilog/dfpm_top.sv
// Function
// - Speed deviation check runs only in vector mode with its trip enable set.
// - Speed beyond deviation band for full detection time blocks output; 20.00 Hz, 1.0 s.
// - Encoder supervision runs only while an encoder module is present.
// - Lost encoder wire for the check time, with checking on, gives encoder trip.
// - Fan mode 0 and fan error block output and raise fan trip.
// - Fan mode 1 keeps running and drives fan warning on outputs selecting 8.
// - Overheat blocks output even while fan errors are only warnings.
// - Power loss with low DC link blocks output and raises low voltage trip.
// - Undervoltage blocks at once; trip follows after delay, default 0.0 s.
// - Low voltage warning on outputs selecting 11, without the trip delay.
//
// Our own choices: the APB slave port and the register offsets.
`include "dfpm_defines.svh"
`default_nettype none
module dfpm_top #(
   parameter int TICK_CYCLES = `DFPM_CLK_HZ / 1000 * `DFPM_TICK_MS,
   parameter int TW = 16
) (
   // Clock, reset, enable
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Control loop, speed error magnitude in 0.01 Hz
   input wire logic [15:0] speed_dev,
   // Sensor pins
   input wire logic enc_present_pin,
   input wire logic enc_wire_ok_pin,
   input wire logic fan_err_pin,
   input wire logic power_lost_pin,
   input wire logic dc_low_pin,
   input wire logic overheat_pin,
   // Protection outputs
   output logic output_block,
   output dfpm_pkg::dfpm_evt_s trips,
   // Relays and open collector
   output logic relay1,
   output logic relay2,
   output logic open_collector,
   // Interrupt
   output logic irq
);
   // ==========================================
   // Elaboration checks
   generate
      if (TICK_CYCLES < 1) begin : g_bad_tick
         $error("TICK_CYCLES must be at least one");
      end
      if (TW < 16 || TW > 32) begin : g_bad_tw
         $error("TW must lie between 16 and 32");
      end
   endgenerate

   // ==========================================
   // Registers
   dfpm_pkg::dfpm_ctrl_s ctrl;
   logic [15:0] spd_band;
   logic [TW-1:0] spd_time;
   logic [TW-1:0] enc_time;
   logic [TW-1:0] undervoltage_trip_delay;
   logic [31:0] out_sel;
   dfpm_pkg::dfpm_evt_s irq_stat;
   dfpm_pkg::dfpm_evt_s irq_en;
   logic [31:0] tick_cnt;
   logic tick;
   dfpm_pkg::dfpm_pins_s pins;
   dfpm_pkg::dfpm_evt_s live;
   dfpm_pkg::dfpm_evt_s live_d;
   dfpm_pkg::dfpm_evt_s evt_rise;
   dfpm_pkg::dfpm_evt_s clr_mask;
   logic spd_cond;
   logic enc_cond;
   logic uv_cond;
   logic spd_exp;
   logic enc_exp;
   logic lv_exp;
   logic wr_en;
   logic rd_en;
   logic trip_clr;
   logic addr_ok;
   logic [31:0] rd_val;
   logic next_block;
   logic [2:0] next_relays;

   // ==========================================
   // Pin synchronisers
   dfpm_sync #(.WIDTH(6)) u_sync (
      .clock(clock),
      .srst(srst),
      .ce(ce),
      .din({overheat_pin, dc_low_pin, power_lost_pin, fan_err_pin, enc_wire_ok_pin, enc_present_pin}),
      .dout(pins)
   );

   // ==========================================
   // Tenth-second tick shared by all detection timers
   always_ff @(posedge clock) begin
      if (srst) begin
         tick_cnt <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (ce) begin
         if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b1;
         end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
            tick <= 1'b0;
         end
      end
   end

   // ==========================================
   // Fault conditions
   assign spd_cond = (ctrl.mode == `DFPM_MODE_VECTOR) && ctrl.spd_trip_en
      && (speed_dev > spd_band);
   assign enc_cond = pins.enc_present
      && ctrl.enc_check_en && !pins.enc_wire_ok;
   assign uv_cond = pins.power_lost && pins.dc_low;

   dfpm_timer #(.WIDTH(TW)) u_spd_tmr (
      .clock(clock),
      .srst(srst),
      .ce(ce),
      .tick(tick),
      .cond(spd_cond),
      .limit(spd_time),
      .expired(spd_exp)
   );

   dfpm_timer #(.WIDTH(TW)) u_enc_tmr (
      .clock(clock),
      .srst(srst),
      .ce(ce),
      .tick(tick),
      .cond(enc_cond),
      .limit(enc_time),
      .expired(enc_exp)
   );

   dfpm_timer #(.WIDTH(TW)) u_lv_tmr (
      .clock(clock),
      .srst(srst),
      .ce(ce),
      .tick(tick),
      .cond(uv_cond),
      .limit(undervoltage_trip_delay),
      .expired(lv_exp)
   );

   // ==========================================
   // Trip latches hold until software clears them
   always_ff @(posedge clock) begin
      if (srst) begin
         trips <= '0;
      end else if (ce) begin
         if (trip_clr) begin
            trips <= '0;
         end
         if (spd_exp) begin
            trips.spd_trip <= 1'b1;
         end
         if (enc_exp) begin
            trips.enc_trip <= 1'b1;
         end
         if (!ctrl.fan_warn_mode && pins.fan_err) begin
            trips.fan_trip <= 1'b1;
         end
         if (lv_exp) begin
            trips.lv_trip <= 1'b1;
         end
         if (trip_clr) begin
            trips.fan_warn <= 1'b0;
         end else begin
            trips.fan_warn <= ctrl.fan_warn_mode && pins.fan_err;
         end
         trips.uv_warn <= uv_cond;
      end
   end

   // ==========================================
   // Output block: undervoltage and overheat act at once
   always_comb begin
      next_block = trips.spd_trip || trips.enc_trip || trips.fan_trip || trips.lv_trip;
      if (uv_cond) begin
         next_block = 1'b1;
      end
      if (pins.overheat) begin
         next_block = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         output_block <= 1'b0;
      end else if (ce) begin
         output_block <= next_block;
      end
   end

   // ==========================================
   // Relay and open-collector function select
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_out
         logic [7:0] fsel;
         assign fsel = out_sel[8*g +: 8];
         always_comb begin
            next_relays[g] = 1'b0;
            if (fsel == `DFPM_FUNC_FAN_WARN) begin
               next_relays[g] = ctrl.fan_warn_mode && pins.fan_err;
            end else if (fsel == `DFPM_FUNC_LOW_VOLT) begin
               next_relays[g] = uv_cond;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (srst) begin
         relay1 <= 1'b0;
         relay2 <= 1'b0;
         open_collector <= 1'b0;
      end else if (ce) begin
         relay1 <= next_relays[0];
         relay2 <= next_relays[1];
         open_collector <= next_relays[2];
      end
   end

   // ==========================================
   // Interrupt events on rising edges of trip and warning bits
   assign live = trips;
   assign evt_rise = live & ~live_d;
   assign clr_mask = (wr_en && paddr == `DFPM_OFS_IRQ_CLR) ? pwdata[5:0] : '0;

   always_ff @(posedge clock) begin
      if (srst) begin
         live_d <= '0;
         irq_stat <= '0;
      end else if (ce) begin
         live_d <= live;
         // Set beats a clear landing in the same cycle
         irq_stat <= (irq_stat & ~clr_mask) | evt_rise;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(irq_stat & irq_en);
      end
   end

   // ==========================================
   // APB slave: one wait state, answer registered
   assign wr_en = psel && penable && !pready && pwrite && ce;
   assign rd_en = psel && penable && !pready && !pwrite;
   assign trip_clr = wr_en && paddr == `DFPM_OFS_TRIP_CLR && pwdata[0];

   always_comb begin
      rd_val = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr)
         `DFPM_OFS_CTRL: rd_val = {25'h0, ctrl.mode, 1'b0, ctrl.fan_warn_mode, ctrl.enc_check_en,
                                   ctrl.spd_trip_en};
         `DFPM_OFS_SPD_BAND: rd_val = {16'h0, spd_band};
         `DFPM_OFS_SPD_TIME: rd_val = 32'(spd_time);
         `DFPM_OFS_ENC_TIME: rd_val = 32'(enc_time);
         `DFPM_OFS_UNDERVOLTAGE_TRIP_DELAY: rd_val = 32'(undervoltage_trip_delay);
         `DFPM_OFS_OUT_SEL: rd_val = {8'h0, out_sel[23:0]};
         `DFPM_OFS_STATUS: rd_val = {24'h0, output_block, pins.enc_present, trips};
         `DFPM_OFS_IRQ_STAT: rd_val = {26'h0, irq_stat};
         `DFPM_OFS_IRQ_CLR: rd_val = 32'h0000_0000;
         `DFPM_OFS_IRQ_EN: rd_val = {26'h0, irq_en};
         `DFPM_OFS_TRIP_CLR: rd_val = 32'h0000_0000;
         default: addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (ce) begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !addr_ok;
         if (rd_en) begin
            prdata <= addr_ok ? rd_val : 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         ctrl <= dfpm_pkg::dfpm_ctrl_s'(`DFPM_RST_CTRL);
         spd_band <= `DFPM_RST_SPD_BAND;
         spd_time <= TW'(`DFPM_RST_SPD_TIME);
         enc_time <= TW'(`DFPM_RST_ENC_TIME);
         undervoltage_trip_delay <= TW'(`DFPM_RST_UNDERVOLTAGE_TRIP_DELAY);
         out_sel <= `DFPM_RST_OUT_SEL;
         irq_en <= '0;
      end else if (wr_en) begin
         case (paddr)
            `DFPM_OFS_CTRL: begin
               ctrl.spd_trip_en <= pwdata[`DFPM_CTRL_SPD_EN];
               ctrl.enc_check_en <= pwdata[`DFPM_CTRL_ENC_EN];
               ctrl.fan_warn_mode <= pwdata[`DFPM_CTRL_FAN_MODE];
               ctrl.mode <= pwdata[`DFPM_CTRL_MODE_MSB:`DFPM_CTRL_MODE_LSB];
            end
            `DFPM_OFS_SPD_BAND: spd_band <= pwdata[15:0];
            `DFPM_OFS_SPD_TIME: spd_time <= pwdata[TW-1:0];
            `DFPM_OFS_ENC_TIME: enc_time <= pwdata[TW-1:0];
            `DFPM_OFS_UNDERVOLTAGE_TRIP_DELAY: undervoltage_trip_delay <= pwdata[TW-1:0];
            `DFPM_OFS_OUT_SEL: out_sel <= {8'h0, pwdata[23:0]};
            `DFPM_OFS_IRQ_EN: irq_en <= pwdata[5:0];
            default: ;
         endcase
      end
   end
endmodule : dfpm_top
`default_nettype wire

// File: tb/dfpm_plant.sv
`default_nettype none
module dfpm_plant (
   // Clock
   input wire logic clock,
   // Requests from the bench
   input wire dfpm_pkg::dfpm_pins_s req,
   input wire logic [15:0] spd_req,
   // Toward the block
   output dfpm_pkg::dfpm_pins_s pins,
   output logic [15:0] speed_dev
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Sensor front end
   // Levels move only just after an edge, so the block never sees a glitch mid-cycle
   always_ff @(posedge clock) begin
      pins <= req;
      speed_dev <= spd_req;
   end
endmodule : dfpm_plant
`default_nettype wire

// File: tb/dfpm_checker.sv
`default_nettype none
module dfpm_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Sensor pins
   input wire logic enc_present_pin,
   input wire logic enc_wire_ok_pin,
   input wire logic fan_err_pin,
   input wire logic power_lost_pin,
   input wire logic dc_low_pin,
   input wire logic overheat_pin,
   // Protection outputs
   input wire logic output_block,
   input wire dfpm_pkg::dfpm_evt_s trips
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // ==========================================
   // Assertions
   // Five samples cover two sync flops and one output register with margin
   a_uv_blocks_warns: assert property (
      (dc_low_pin && power_lost_pin)[*5] |-> output_block && trips.uv_warn)
      else $error("undervoltage without block or warning");
   a_uv_warn_prompt: assert property ($rose(dc_low_pin && power_lost_pin) |-> ##[1:4] trips.uv_warn)
      else $error("low voltage warning late");
   a_uv_warn_drops: assert property ((!dc_low_pin)[*5] |-> !trips.uv_warn)
      else $error("low voltage warning without cause");
   a_overheat_blocks: assert property (overheat_pin[*5] |-> output_block)
      else $error("overheat not blocking");
   a_trip_holds_block: assert property ((|trips[3:0])[*2] |-> output_block)
      else $error("latched trip without block");
   a_fan_trip_cause: assert property ((!fan_err_pin)[*5] |-> !$rose(trips.fan_trip))
      else $error("fan trip without fan error");
   a_fan_warn_follow: assert property ((!fan_err_pin)[*5] |-> !trips.fan_warn)
      else $error("fan warning without fan error");
   a_enc_needs_module: assert property ((!enc_present_pin)[*5] |-> !$rose(trips.enc_trip))
      else $error("encoder trip without module");
   a_enc_wire_cause: assert property (enc_wire_ok_pin[*5] |-> !$rose(trips.enc_trip))
      else $error("encoder trip with wire good");
   a_lv_trip_cause: assert property ((!power_lost_pin)[*5] |-> !$rose(trips.lv_trip))
      else $error("low voltage trip with power present");
endmodule : dfpm_checker
bind dfpm_top dfpm_checker i_chk (.clock(clock), .srst(srst), .enc_present_pin(enc_present_pin),
   .enc_wire_ok_pin(enc_wire_ok_pin), .fan_err_pin(fan_err_pin), .power_lost_pin(power_lost_pin),
   .dc_low_pin(dc_low_pin), .overheat_pin(overheat_pin), .output_block(output_block), .trips(trips));
`default_nettype wire

// File: tb/test_drive_fault_protection_monitor.sv
`include "dfpm_defines.svh"
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module test_drive_fault_protection_monitor;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] ST = `DFPM_OFS_STATUS;
   localparam logic [7:0] CT = `DFPM_OFS_CTRL;
   localparam logic [7:0] TC = `DFPM_OFS_TRIP_CLR;
   logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic pready, pslverr, ob, r1, r2, oc, irq;
   logic [15:0] spd_req = 0, speed_dev;
   dfpm_pkg::dfpm_evt_s trips;
   dfpm_pkg::dfpm_pins_s req = 6'h02, pins;
   int err_total = 0, checks_done = 0;
   logic [31:0] q_d[$];
   logic q_e[$];
   int c0[2] = '{32'h01, 32'h40};
   always #10 clock = ~clock;
   dfpm_plant i_plant (.clock(clock), .req(req), .spd_req(spd_req), .pins(pins), .speed_dev(speed_dev));
   dfpm_top #(.TICK_CYCLES(10)) i_dut (.clock(clock), .srst(srst), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .speed_dev(speed_dev), .enc_present_pin(pins.enc_present), .enc_wire_ok_pin(pins.enc_wire_ok),
      .fan_err_pin(pins.fan_err), .power_lost_pin(pins.power_lost), .dc_low_pin(pins.dc_low),
      .overheat_pin(pins.overheat), .output_block(ob), .trips(trips), .relay1(r1), .relay2(r2),
      .open_collector(oc), .irq(irq));
   // ==========================================
   // Bus tasks
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      // Only the watchdog ends a wait that never sees pready
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
      q_d.push_back(e);
      q_e.push_back(er);
      apb(0, a, 32'h0);
   endtask : rd
   task automatic tk(input int n);
      repeat (n) @(posedge clock);
   endtask : tk
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   // ==========================================
   // Read answers checked against the oldest note
   // Notes are popped once into locals, since the macro names its operands twice
   always @(posedge clock) begin : mon
      logic [31:0] exp_d;
      logic exp_e;
      if (psel && penable && !pwrite && pready === 1'b1) begin
         if (q_d.size() == 0) begin
            `CHK(1'b1, 1'b0)
         end else begin
            exp_d = q_d.pop_front();
            exp_e = q_e.pop_front();
            `CHK(prdata, exp_d)
            `CHK(pslverr, exp_e)
         end
      end
   end
   initial begin
      tk(20000);
      err_total++;
      end_sim();
   end
   // ==========================================
   // Scenarios
   initial begin
      void'($urandom(32'h6aea));
      tk(2);
      srst <= 0;
      rd(CT, 32'h3, 0);
      rd(`DFPM_OFS_SPD_BAND, 32'h7d0, 0);
      rd(`DFPM_OFS_SPD_TIME, 32'ha, 0);
      rd(`DFPM_OFS_ENC_TIME, 32'ha, 0);
      rd(`DFPM_OFS_UNDERVOLTAGE_TRIP_DELAY, 32'h0, 0);
      rd(8'h2c, 32'h0, 1);
      // Speed: wrong mode or trip disabled must never trip
      foreach (c0[i]) begin
         wr(CT, c0[i]);
         spd_req <= 16'(2001 + $urandom % 100);
         tk(80);
         rd(ST, 32'h0, 0);
         spd_req <= 16'($urandom % 2001);
      end
      wr(CT, 32'h41);
      wr(`DFPM_OFS_SPD_TIME, 32'h5);
      wr(`DFPM_OFS_IRQ_EN, 32'h1);
      repeat (2) begin
         spd_req <= 16'(2001 + $urandom % 100);
         tk(30);
         spd_req <= 16'($urandom % 2001);
         tk(3);
      end
      rd(ST, 32'h0, 0);
      spd_req <= 16'(2001 + $urandom % 100);
      tk(80);
      rd(ST, 32'h81, 0);
      `CHK(irq, 1'b1)
      spd_req <= 16'($urandom % 2001);
      wr(`DFPM_OFS_IRQ_EN, 32'h0);
      tk(2);
      `CHK(irq, 1'b0)
      rd(`DFPM_OFS_IRQ_STAT, 32'h1, 0);
      wr(`DFPM_OFS_IRQ_CLR, 32'h1);
      wr(TC, 32'h1);
      rd(`DFPM_OFS_IRQ_STAT, 32'h0, 0);
      rd(ST, 32'h0, 0);
      // Encoder: module absent, then check off, then check on
      wr(CT, 32'h2);
      wr(`DFPM_OFS_ENC_TIME, 32'h2);
      req <= 6'h00;
      tk(60);
      rd(ST, 32'h0, 0);
      req <= 6'h01;
      wr(CT, 32'h0);
      tk(60);
      rd(ST, 32'h40, 0);
      wr(CT, 32'h2);
      tk(60);
      rd(ST, 32'hc2, 0);
      req <= 6'h03;
      tk(4);
      wr(TC, 32'h1);
      rd(ST, 32'h40, 0);
      // Fan: trip mode, then warning mode with overheat
      wr(`DFPM_OFS_OUT_SEL, 32'h00080b08);
      wr(CT, 32'h0);
      req <= 6'h07;
      tk(8);
      rd(ST, 32'hc4, 0);
      wr(CT, 32'h4);
      wr(TC, 32'h1);
      rd(ST, 32'h50, 0);
      `CHK({r1, r2, oc}, 3'b101)
      req <= 6'h27;
      tk(8);
      rd(ST, 32'hd0, 0);
      req <= 6'h03;
      tk(8);
      rd(ST, 32'h40, 0);
      // Low voltage: power loss alone, then with low link and delay
      wr(`DFPM_OFS_UNDERVOLTAGE_TRIP_DELAY, 32'h3);
      req <= 6'h0b;
      tk(10);
      rd(ST, 32'h40, 0);
      req <= 6'h1b;
      tk(6);
      rd(ST, 32'he0, 0);
      `CHK(r2, 1'b1)
      tk(50);
      rd(ST, 32'he8, 0);
      req <= 6'h03;
      tk(8);
      wr(TC, 32'h1);
      rd(ST, 32'h40, 0);
      `CHK(r2, 1'b0)
      tk(4);
      end_sim();
   end
endmodule : test_drive_fault_protection_monitor
`default_nettype wire
